// ===== hdl/timer_pkg.sv
// Constants, types and helper functions for the two-channel timer.
// Assumes a single clock domain and an APB register slave in the top module.
package timer_pkg;
  localparam int CNT_W = 16;
  // Register byte addresses
  localparam logic [7:0] ADDR_TIMER_CTL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_MODULO = 8'h08;
  localparam logic [7:0] ADDR_CH0_SC = 8'h0C;
  localparam logic [7:0] ADDR_CH0_VAL = 8'h10;
  localparam logic [7:0] ADDR_CH1_SC = 8'h14;
  localparam logic [7:0] ADDR_CH1_VAL = 8'h18;
  // Channel status/control field positions
  localparam int SC_FLAG = 7;
  localparam int SC_IE = 6;
  localparam int SC_BUF = 5;
  localparam int SC_OUT = 4;
  localparam int SC_ELSB = 3;
  localparam int SC_ELSA = 2;
  localparam int SC_TOV = 1;
  localparam int SC_MAX = 0;
  // Timer control field positions
  localparam int TC_OVF = 7;
  localparam int TC_OVIE = 6;
  localparam int TC_STOP = 5;
  localparam int TC_CRST = 4;
  // Reset values
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] MODULO_RESET = 16'hFFFF;
  // Edge/level select codes: capture edge in input mode, pin action in output mode
  localparam logic [1:0] ELS_OFF = 2'b00;
  localparam logic [1:0] ELS_RISE_TOGGLE = 2'b01;
  localparam logic [1:0] ELS_FALL_CLEAR = 2'b10;
  localparam logic [1:0] ELS_ANY_SET = 2'b11;

  typedef enum logic {SEL_CH0 = 1'b0, SEL_CH1 = 1'b1} buf_sel_type;

  function automatic logic edge_hit(input logic [1:0] els, input logic rise, input logic fall);
    return ((els == ELS_RISE_TOGGLE) && rise) || ((els == ELS_FALL_CLEAR) && fall) ||
           ((els == ELS_ANY_SET) && (rise || fall));
  endfunction

  // Next pin level for an output channel
  function automatic logic pin_next(input logic cur, input logic [1:0] els, input logic tov,
                                    input logic max, input logic ovf, input logic match);
    logic r;
    r = cur;
    if (ovf && tov) r = ~r;
    if (match && (els == ELS_RISE_TOGGLE)) r = ~r;
    if (match && (els == ELS_FALL_CLEAR)) r = 1'b0;
    if (match && (els == ELS_ANY_SET)) r = 1'b1;
    // Forced duty: clear-on-compare polarity holds high, set-on-compare holds low
    if (max) r = (els == ELS_FALL_CLEAR);
    return r;
  endfunction
endpackage

// ===== hdl/chan_if.sv
// Signal bundle between the timer top and one channel module.
// Assumes both ends share the top module's clock.
`timescale 1ns/1ns
interface chan_if;
  logic sc_wr;
  logic sc_rd;
  logic val_wr;
  logic capture_en;
  logic event_set;
  logic [15:0] wdata;
  logic [15:0] count;
  logic [7:0] sc;
  logic [15:0] val;
  logic raw_match;
  logic edge_evt;
  modport hub (output sc_wr, sc_rd, val_wr, capture_en, event_set, wdata, count,
               input sc, val, raw_match, edge_evt);
  modport chan (input sc_wr, sc_rd, val_wr, capture_en, event_set, wdata, count,
                output sc, val, raw_match, edge_evt);
endinterface

// ===== hdl/timer_channel.sv
// One timer channel: status/control, compare/capture value, flag handshake, pin edge detect.
// Assumes the hub decides which events set the flag and drives the pin outputs.
`timescale 1ns/1ns
module timer_channel
  import timer_pkg::*;
#(
  parameter bit HAS_BUF = 1'b0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic pin_in,
  chan_if.chan bus
);
  logic sync1_reg, sync2_reg, prev_reg;
  logic flag_reg, arm_reg;
  logic [6:0] ctl_reg;
  logic [CNT_W-1:0] val_reg;
  logic rise, fall, clear_ok;
  logic [1:0] els;
  logic [6:0] ctl_next;

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;
  assign els = ctl_reg[SC_ELSB:SC_ELSA];
  assign bus.edge_evt = bus.capture_en & edge_hit(els, rise, fall);
  // A new event in the same cycle beats the zero write
  assign clear_ok = bus.sc_wr & ~bus.wdata[SC_FLAG] & arm_reg & ~bus.event_set;
  // Only a buffered-capable channel keeps the mode bit
  assign ctl_next = HAS_BUF ? bus.wdata[6:0] : {bus.wdata[SC_IE], 1'b0, bus.wdata[4:0]};
  assign bus.sc = {flag_reg, ctl_reg};
  assign bus.val = val_reg;
  assign bus.raw_match = (bus.count == val_reg);

  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_reg <= SC_RESET[6:0];
      flag_reg <= 1'b0;
      arm_reg <= 1'b0;
    end else begin
      if (bus.sc_wr) ctl_reg <= ctl_next;
      if (bus.event_set) flag_reg <= 1'b1;
      else if (clear_ok) flag_reg <= 1'b0;
      if (bus.event_set || bus.sc_wr) arm_reg <= 1'b0;
      else if (bus.sc_rd && flag_reg) arm_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) val_reg <= COUNT_RESET;
    else if (bus.edge_evt) val_reg <= bus.count;
    else if (bus.val_wr) val_reg <= bus.wdata;
  end
endmodule // timer_channel

// ===== hdl/timer_top.sv
// Two-channel timer with capture, compare, buffered compare and PWM, APB register slave.
// Assumes an APB3 master on clk; channel pins arrive asynchronously and are synchronised.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
// Function
// - Unbuffered compare value is simply overwritten.
// - Late write past new value skips compare.
// - Compare interrupt raised at counter match.
// - Overflow interrupt raised at every overflow.
// - Larger value written at match compares twice.
// - Channel 0 mode bit links channels, pin 0.
// - Buffered mode starts with channel 0 values.
// - Last written pair takes over at overflow.
// - Channel 0 control governs buffered; channel 1 ignored.
// - Buffered mode releases channel 1 pin.
// - Writing active pair acts immediately.
// - Pin toggles at modulo, setting period.
// - Overflow to compare sets pulse width.
// - Control selects edge, action, toggle, duty, buffering.
// - Capture edge sets channel flag.
// - Compare match sets channel flag.
// - Flag clears by read-set then write-zero.
// - Event during clear sequence keeps flag set.
// - Reset clears flag; writing one ignored.
// - Interrupt enable gates requests; reset clears.
// - Buffered select exists only on channel 0.
module timer_top
  import timer_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ch0_pin_in,
  output logic ch0_pin_out,
  output logic ch0_pin_oe,
  input wire logic ch1_pin_in,
  output logic ch1_pin_out,
  output logic ch1_pin_oe,
  output logic ch0_irq,
  output logic ch1_irq,
  output logic overflow_irq
);
  chan_if c0();
  chan_if c1();

  logic [CNT_W-1:0] count_reg, count_next;
  logic [CNT_W-1:0] modulo_reg;
  logic ovf_flag_reg, ovf_arm_reg, ovie_reg, stop_reg;
  logic [31:0] prdata_reg, rd_mux;
  logic buf_prev_reg;
  buf_sel_type active_reg, pending_reg;
  logic out0_reg, out1_reg, oe0_reg, oe1_reg;
  logic irq0_reg, irq1_reg, irqo_reg;

  // Bus decode
  logic setup, acc, wr, rd;
  logic hit_tc, hit_cnt, hit_mod, hit_sc0, hit_val0, hit_sc1, hit_val1, hit;
  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign hit_tc = (paddr == ADDR_TIMER_CTL);
  assign hit_cnt = (paddr == ADDR_COUNT);
  assign hit_mod = (paddr == ADDR_MODULO);
  assign hit_sc0 = (paddr == ADDR_CH0_SC);
  assign hit_val0 = (paddr == ADDR_CH0_VAL);
  assign hit_sc1 = (paddr == ADDR_CH1_SC);
  assign hit_val1 = (paddr == ADDR_CH1_VAL);
  assign hit = hit_tc | hit_cnt | hit_mod | hit_sc0 | hit_val0 | hit_sc1 | hit_val1;
  // Zero wait states: read data is latched in the setup cycle
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata = prdata_reg;

  // Counter
  logic tick, ovf, wrap, ovf_clear_ok;
  logic tc_wr, crst;
  assign tick = ~stop_reg;
  assign wrap = (count_reg == modulo_reg);
  assign ovf = tick & wrap;
  assign count_next = wrap ? COUNT_RESET : count_reg + 16'h0001;
  assign tc_wr = wr & hit_tc;
  assign crst = tc_wr & pwdata[TC_CRST];
  assign ovf_clear_ok = tc_wr & ~pwdata[TC_OVF] & ovf_arm_reg & ~ovf;

  // Channel control decode
  logic [7:0] sc0, sc1;
  logic buf_mode, buf_enter;
  logic out_mode0, out_mode1;
  logic [1:0] els0, els1;
  assign sc0 = c0.sc;
  assign sc1 = c1.sc;
  assign buf_mode = sc0[SC_BUF];
  assign buf_enter = buf_mode & ~buf_prev_reg;
  assign out_mode0 = sc0[SC_OUT] | buf_mode;
  // Channel 1 control is dead while linked
  assign out_mode1 = sc1[SC_OUT] & ~buf_mode;
  assign els0 = sc0[SC_ELSB:SC_ELSA];
  assign els1 = sc1[SC_ELSB:SC_ELSA];

  // Compare events; equality against the live value skips a passed compare
  logic m0, m1, buf_match, ev0, ev1;
  assign buf_match = (active_reg == SEL_CH1) ? c1.raw_match : c0.raw_match;
  assign m0 = tick & out_mode0 & (buf_mode ? buf_match : c0.raw_match);
  assign m1 = tick & out_mode1 & c1.raw_match;
  assign ev0 = m0 | c0.edge_evt;
  assign ev1 = m1 | c1.edge_evt;

  // Hub side of channel 0
  assign c0.sc_wr = wr & hit_sc0;
  assign c0.sc_rd = rd & hit_sc0;
  assign c0.val_wr = wr & hit_val0;
  assign c0.capture_en = ~out_mode0;
  assign c0.event_set = ev0;
  assign c0.wdata = pwdata[15:0];
  assign c0.count = count_reg;

  // Hub side of channel 1
  assign c1.sc_wr = wr & hit_sc1;
  assign c1.sc_rd = rd & hit_sc1;
  assign c1.val_wr = wr & hit_val1;
  assign c1.capture_en = ~sc1[SC_OUT] & ~buf_mode;
  assign c1.event_set = ev1;
  assign c1.wdata = pwdata[15:0];
  assign c1.count = count_reg;

  timer_channel #(.HAS_BUF(1'b1)) u_ch0 (
    .clk(clk),
    .srst(srst),
    .pin_in(ch0_pin_in),
    .bus(c0.chan)
  );

  timer_channel #(.HAS_BUF(1'b0)) u_ch1 (
    .clk(clk),
    .srst(srst),
    .pin_in(ch1_pin_in),
    .bus(c1.chan)
  );

  // Read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_tc) rd_mux[7:0] = {ovf_flag_reg, ovie_reg, stop_reg, 5'b0_0000};
    if (hit_cnt) rd_mux[15:0] = count_reg;
    if (hit_mod) rd_mux[15:0] = modulo_reg;
    if (hit_sc0) rd_mux[7:0] = sc0;
    if (hit_val0) rd_mux[15:0] = c0.val;
    if (hit_sc1) rd_mux[7:0] = sc1;
    if (hit_val1) rd_mux[15:0] = c1.val;
  end

  always_ff @(posedge clk) begin
    if (srst) prdata_reg <= 32'h0000_0000;
    else if (setup && !pwrite) prdata_reg <= rd_mux;
  end

  always_ff @(posedge clk) begin
    if (srst) count_reg <= COUNT_RESET;
    else if (crst) count_reg <= COUNT_RESET;
    else if (tick) count_reg <= count_next;
  end

  always_ff @(posedge clk) begin
    if (srst) modulo_reg <= MODULO_RESET;
    else if (wr && hit_mod) modulo_reg <= pwdata[15:0];
  end

  // Timer control and overflow flag with the same clearing handshake as the channels
  always_ff @(posedge clk) begin
    if (srst) begin
      ovie_reg <= 1'b0;
      stop_reg <= 1'b0;
      ovf_flag_reg <= 1'b0;
      ovf_arm_reg <= 1'b0;
    end else begin
      if (tc_wr) begin
        ovie_reg <= pwdata[TC_OVIE];
        stop_reg <= pwdata[TC_STOP];
      end
      if (ovf) ovf_flag_reg <= 1'b1;
      else if (ovf_clear_ok) ovf_flag_reg <= 1'b0;
      if (ovf || tc_wr) ovf_arm_reg <= 1'b0;
      else if (rd && hit_tc && ovf_flag_reg) ovf_arm_reg <= 1'b1;
    end
  end

  // Buffered pair selection; handover waits for overflow so the edge stays synchronous
  always_ff @(posedge clk) begin
    if (srst) begin
      buf_prev_reg <= 1'b0;
      active_reg <= SEL_CH0;
      pending_reg <= SEL_CH0;
    end else begin
      buf_prev_reg <= buf_mode;
      if (buf_enter) begin
        active_reg <= SEL_CH0;
        pending_reg <= SEL_CH0;
      end else if (buf_mode) begin
        if (wr && hit_val1) pending_reg <= SEL_CH1;
        else if (wr && hit_val0) pending_reg <= SEL_CH0;
        if (ovf) begin
          if (wr && hit_val1) active_reg <= SEL_CH1;
          else if (wr && hit_val0) active_reg <= SEL_CH0;
          else active_reg <= pending_reg;
        end
      end
    end
  end

  // Pin drivers; an input-mode channel keeps its last output level
  always_ff @(posedge clk) begin
    if (srst) begin
      out0_reg <= 1'b0;
      out1_reg <= 1'b0;
      oe0_reg <= 1'b0;
      oe1_reg <= 1'b0;
    end else begin
      if (out_mode0) out0_reg <= pin_next(out0_reg, els0, sc0[SC_TOV], sc0[SC_MAX], ovf, m0);
      if (out_mode1) out1_reg <= pin_next(out1_reg, els1, sc1[SC_TOV], sc1[SC_MAX], ovf, m1);
      oe0_reg <= out_mode0 & (els0 != ELS_OFF);
      oe1_reg <= out_mode1 & (els1 != ELS_OFF);
    end
  end

  // Interrupt requests rise with the flag; they follow enable changes and flag clears one cycle later
  always_ff @(posedge clk) begin
    if (srst) begin
      irq0_reg <= 1'b0;
      irq1_reg <= 1'b0;
      irqo_reg <= 1'b0;
    end else begin
      irq0_reg <= (sc0[SC_FLAG] | ev0) & sc0[SC_IE];
      irq1_reg <= (sc1[SC_FLAG] | ev1) & sc1[SC_IE] & ~buf_mode;
      irqo_reg <= (ovf_flag_reg | ovf) & ovie_reg;
    end
  end

  assign ch0_pin_out = out0_reg;
  assign ch1_pin_out = out1_reg;
  assign ch0_pin_oe = oe0_reg;
  assign ch1_pin_oe = oe1_reg;
  assign ch0_irq = irq0_reg;
  assign ch1_irq = irq1_reg;
  assign overflow_irq = irqo_reg;
endmodule // timer_top

// ===== test/pin_model.sv
// Far-side model of the two channel pins.
// Assumes the bench sets ext_lvl; a pin that the block drives reads back its own level.
`timescale 1ns/1ns
module pin_model (
  input wire logic [1:0] ext_lvl,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pin_in
);
  // A released pin, such as channel 1 in buffered mode, sees only the far side
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // pin_model

// ===== test/timer_top_assertions.sv
// Port-level checks for the two-channel timer, bound onto its top module.
// Assumes APB writes land in the access cycle, as pready stays high.
`timescale 1ns/1ns
module timer_top_assertions
  import timer_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic ch0_pin_in,
  input wire logic ch1_pin_oe,
  input wire logic ch0_irq,
  input wire logic ch1_irq,
  input wire logic overflow_irq
);
  // Shadow of the fields that software writes and the block keeps verbatim
  logic [6:0] sc0_reg;
  logic sc1_ie_reg;
  logic ovie_reg;
  logic wr_done;
  logic rd_acc;
  logic buf_on;
  assign wr_done = psel && penable && pwrite && pready;
  assign rd_acc = psel && penable && !pwrite;
  assign buf_on = sc0_reg[SC_BUF];
  always_ff @(posedge clk) begin
    if (srst) begin
      sc0_reg <= 7'h00;
      sc1_ie_reg <= 1'b0;
      ovie_reg <= 1'b0;
    end else if (wr_done) begin
      if (paddr == ADDR_CH0_SC) sc0_reg <= pwdata[6:0];
      if (paddr == ADDR_CH1_SC) sc1_ie_reg <= pwdata[SC_IE];
      if (paddr == ADDR_TIMER_CTL) ovie_reg <= pwdata[TC_OVIE];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ie_gate_a: assert property (!sc0_reg[SC_IE] && !$past(sc0_reg[SC_IE]) |-> !ch0_irq)
    else $error("ch0 irq while its enable is clear");
  ch1_gate_a: assert property ($rose(ch1_irq) |-> $past(sc1_ie_reg))
    else $error("ch1 irq rose with its enable clear");
  ovf_gate_a: assert property (!ovie_reg ##1 !ovie_reg |-> !overflow_irq)
    else $error("overflow irq while its enable is clear");
  buf_release_a: assert property (buf_on [*3] |-> !ch1_pin_oe)
    else $error("ch1 pin still driven in buffered mode");
  buf_quiet_a: assert property (buf_on [*3] |-> !ch1_irq)
    else $error("ch1 irq in buffered mode");
  capture_irq_a: assert property (sc0_reg == 7'h44 && $rose(ch0_pin_in) |-> ##[2:6] ch0_irq)
    else $error("rising capture edge gave no ch0 irq");
  ch1_nobuf_a: assert property (rd_acc && paddr == ADDR_CH1_SC |-> !prdata[SC_BUF])
    else $error("ch1 reads back a buffered select bit");
  sc_readback_a: assert property (rd_acc && paddr == ADDR_CH0_SC |-> prdata[6:5] == sc0_reg[6:5])
    else $error("ch0 enable or buffered select reads wrong");
endmodule // timer_top_assertions
bind timer_top timer_top_assertions port_chk (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .ch0_pin_in, .ch1_pin_oe, .ch0_irq, .ch1_irq, .overflow_irq);

// ===== test/timer_top_tb.sv
// Self-checking bench for the two-channel timer: APB master, pin model, scenarios.
// Assumes the bound port checker and the pin model are compiled alongside.
`timescale 1ns/1ns
module timer_top_tb
  import timer_pkg::*;
;
  localparam logic [15:0] MODV = 16'h0030;
  localparam logic [15:0] V0 = 16'h0010;
  localparam logic [15:0] V1 = 16'h0020;
  logic clk = 1'b0;
  logic srst, psel, penable, pwrite, pready, pslverr, ch0_irq, ch1_irq, overflow_irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] ext_lvl, pin_out, pin_oe, pin_in;
  int failures = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  timer_top dut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ch0_pin_in(pin_in[0]), .ch0_pin_out(pin_out[0]), .ch0_pin_oe(pin_oe[0]), .ch1_pin_in(pin_in[1]),
    .ch1_pin_out(pin_out[1]), .ch1_pin_oe(pin_oe[1]), .ch0_irq, .ch1_irq, .overflow_irq);
  pin_model far (.ext_lvl, .pin_out, .pin_oe, .pin_in);
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // Edge times rather than sampled levels, so pin and clock updates never race
  task automatic pwm_meas(input logic [15:0] v);
    time t0, t1, t2;
    @(posedge pin_out[0]) t0 = $time;
    @(negedge pin_out[0]) t1 = $time;
    @(posedge pin_out[0]) t2 = $time;
    check("pwm_high", 32'((t1 - t0) / 40), {16'h0000, v} + 32'h0000_0001);
    check("pwm_period", 32'((t2 - t0) / 40), {16'h0000, MODV} + 32'h0000_0001);
  endtask
  task automatic t_reset();
    rd(ADDR_CH0_SC);
    check("ch0_sc_reset", q, {24'h00_0000, SC_RESET});
    rd(ADDR_CH1_SC);
    check("ch1_sc_reset", q, {24'h00_0000, SC_RESET});
    rd(ADDR_MODULO);
    check("modulo_reset", q, {16'h0000, MODULO_RESET});
    rd(8'h1C);
    check("unmapped_err", {31'h0000_0000, err}, 32'h0000_0001);
    wr(ADDR_CH0_SC, 16'h0080);
    rd(ADDR_CH0_SC);
    check("flag_write_one", q, 32'h0000_0000);
    $display("t_reset done");
  endtask
  task automatic t_capture();
    wr(ADDR_CH0_SC, 16'h0044);
    ext_lvl[0] <= 1'b1;
    repeat (6) @(posedge clk);
    check("cap_irq", {31'h0000_0000, ch0_irq}, 32'h0000_0001);
    rd(ADDR_CH0_SC);
    check("cap_flag", q, 32'h0000_00C4);
    ext_lvl[0] <= 1'b0;
    wr(ADDR_CH0_SC, 16'h0044);
    rd(ADDR_CH0_SC);
    check("flag_cleared", q, 32'h0000_0044);
    check("irq_cleared", {31'h0000_0000, ch0_irq}, 32'h0000_0000);
    ext_lvl[0] <= 1'b1;
    repeat (6) @(posedge clk);
    ext_lvl[0] <= 1'b0;
    rd(ADDR_CH0_SC);
    ext_lvl[0] <= 1'b1;
    repeat (6) @(posedge clk);
    wr(ADDR_CH0_SC, 16'h0044);
    rd(ADDR_CH0_SC);
    check("flag_kept", q, 32'h0000_00C4);
    $display("t_capture done");
  endtask
  task automatic t_pwm();
    wr(ADDR_MODULO, MODV);
    wr(ADDR_CH0_VAL, V0);
    wr(ADDR_TIMER_CTL, 16'h0010);
    wr(ADDR_CH0_SC, 16'h001A);
    pwm_meas(V0);
    check("ch0_oe", {31'h0000_0000, pin_oe[0]}, 32'h0000_0001);
    wr(ADDR_CH0_VAL, V1);
    pwm_meas(V1);
    rd(ADDR_CH0_SC);
    wr(ADDR_CH0_SC, 16'h005A);
    @(posedge clk);
    check("irq_idle", {31'h0000_0000, ch0_irq}, 32'h0000_0000);
    @(negedge pin_out[0]);
    @(posedge clk);
    check("cmp_irq", {31'h0000_0000, ch0_irq}, 32'h0000_0001);
    rd(ADDR_CH0_SC);
    check("cmp_flag", q, 32'h0000_00DA);
    rd(ADDR_TIMER_CTL);
    wr(ADDR_TIMER_CTL, 16'h0040);
    @(posedge overflow_irq);
    @(posedge clk);
    check("ovf_at_wrap", {31'h0000_0000, pin_out[0]}, 32'h0000_0001);
    wr(ADDR_CH0_SC, 16'h001B);
    repeat (60) @(posedge clk);
    check("duty_full", {31'h0000_0000, pin_out[0]}, 32'h0000_0001);
    wr(ADDR_CH0_SC, 16'h001D);
    repeat (60) @(posedge clk);
    check("duty_none", {31'h0000_0000, pin_out[0]}, 32'h0000_0000);
    $display("t_pwm done");
  endtask
  task automatic t_buffered();
    wr(ADDR_CH0_VAL, V0);
    wr(ADDR_CH0_SC, 16'h003A);
    pwm_meas(V0);
    check("ch1_oe", {31'h0000_0000, pin_oe[1]}, 32'h0000_0000);
    check("ch1_out", {31'h0000_0000, pin_out[1]}, 32'h0000_0000);
    wr(ADDR_CH1_VAL, V1);
    pwm_meas(V1);
    wr(ADDR_CH1_SC, 16'h0064);
    rd(ADDR_CH1_SC);
    check("ch1_no_buf", {31'h0000_0000, q[SC_BUF]}, 32'h0000_0000);
    ext_lvl[1] <= 1'b1;
    repeat (6) @(posedge clk);
    check("ch1_quiet", {31'h0000_0000, ch1_irq}, 32'h0000_0000);
    $display("t_buffered done");
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done();
  end
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ext_lvl = 2'h0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_capture();
    t_pwm();
    t_buffered();
    test_done();
  end
endmodule // timer_top_tb
